// ---- timer_basic.sv ----
// basic 16-bit up-count timer with apb registers and trigger output
`timescale 1ns/100ps
`default_nettype none
module timer_basic
  import timer_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  input  wire timer_pkg::apb_req_s APB_REQ,
  output timer_pkg::apb_rsp_s      APB_RSP,
  input  wire logic                MASTER_RESET_IN,
  input  wire logic                PAUSE_TRIGGER_IN,
  output logic                     TRIGGER_OUTPUT,
  output logic                     UPDATE_DMA_REQ,
  output logic                     UPDATE_IRQ
);

  bus_state_e       state_r;
  bus_state_e       state_nxt;
  apb_rsp_s         rsp_r;
  apb_rsp_s         rsp_nxt;

  logic             count_enable_r;
  logic             update_disable_r;
  logic             update_source_select_r;
  logic             single_pulse_mode_r;
  logic             reload_shadow_enable_r;
  logic [2:0]       mms_r;
  logic             update_irq_enable_r;
  logic             update_dma_enable_r;
  logic             update_event_flag_r;
  logic [CNT_W-1:0] counter_value_r;
  logic [CNT_W-1:0] prescaler_value_r;
  logic [CNT_W-1:0] reload_pre_r;
  logic [CNT_W-1:0] reload_act_r;
  logic             trg_r;
  logic             dma_r;
  logic             irq_r;

  logic             mrst_s1_r;
  logic             mrst_s2_r;
  logic             mrst_q_r;
  logic             pause_s1_r;
  logic             pause_s2_r;
  logic             start_q_r;

  // exact word address compare, used by every decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // bus phase decode
  wire              access   = APB_REQ.psel & APB_REQ.penable;
  wire              rd_start = access & (state_r == BUS_IDLE);
  wire              bus_done = access & (state_r == BUS_RESP);
  wire              wr_done  = bus_done & APB_REQ.pwrite;
  wire [DATA_W-1:0] wd       = APB_REQ.pwdata;
  wire [ADDR_W-1:0] ad       = APB_REQ.paddr;

  // write strobes, taken only at the completing edge
  wire wr_ctl0  = wr_done & hit(ad, OFS_CONTROL_0);
  wire wr_ctl1  = wr_done & hit(ad, OFS_CONTROL_1);
  wire wr_inten = wr_done & hit(ad, OFS_DMA_IRQ_ENABLE);
  wire wr_flags = wr_done & hit(ad, OFS_IRQ_FLAGS);
  wire wr_swev  = wr_done & hit(ad, OFS_SOFTWARE_EVENT);
  wire wr_cnt   = wr_done & hit(ad, OFS_COUNTER_VALUE);
  wire wr_psc   = wr_done & hit(ad, OFS_CLOCK_DIVIDER);
  wire wr_arr   = wr_done & hit(ad, OFS_AUTO_RELOAD);

  wire mapped = hit(ad, OFS_CONTROL_0) | hit(ad, OFS_CONTROL_1) |
                hit(ad, OFS_DMA_IRQ_ENABLE) | hit(ad, OFS_IRQ_FLAGS) |
                hit(ad, OFS_SOFTWARE_EVENT) | hit(ad, OFS_COUNTER_VALUE) |
                hit(ad, OFS_CLOCK_DIVIDER) | hit(ad, OFS_AUTO_RELOAD);

  // read words; unlisted bits stay zero
  wire [DATA_W-1:0] rd_ctl0 = {24'h000000, reload_shadow_enable_r, 3'h0,
                               single_pulse_mode_r, update_source_select_r,
                               update_disable_r, count_enable_r};
  wire [DATA_W-1:0] rd_ctl1  = {25'h0000000, mms_r, 4'h0};
  wire [DATA_W-1:0] rd_inten = {23'h000000, update_dma_enable_r, 7'h00,
                                update_irq_enable_r};
  wire [DATA_W-1:0] rd_flags = {31'h00000000, update_event_flag_r};
  wire [DATA_W-1:0] rd_cnt   = {16'h0000, counter_value_r};
  wire [DATA_W-1:0] rd_psc   = {16'h0000, prescaler_value_r};
  wire [DATA_W-1:0] rd_arr   = {16'h0000, reload_pre_r};

  // the request bit is never stored, so it always reads zero
  wire [DATA_W-1:0] rd_word =
    hit(ad, OFS_CONTROL_0)      ? rd_ctl0  :
    hit(ad, OFS_CONTROL_1)      ? rd_ctl1  :
    hit(ad, OFS_DMA_IRQ_ENABLE) ? rd_inten :
    hit(ad, OFS_IRQ_FLAGS)      ? rd_flags :
    hit(ad, OFS_COUNTER_VALUE)  ? rd_cnt   :
    hit(ad, OFS_CLOCK_DIVIDER)  ? rd_psc   :
    hit(ad, OFS_AUTO_RELOAD)    ? rd_arr   : WORD_RST;

  // one wait state: answer is registered in the first access cycle
  always_comb
  begin
    state_nxt = state_r;
    rsp_nxt   = rsp_r;
    case (state_r)
      BUS_IDLE:
      begin
        if (rd_start)
        begin
          state_nxt       = BUS_RESP;
          rsp_nxt.pready  = 1'b1;
          rsp_nxt.prdata  = APB_REQ.pwrite ? WORD_RST : rd_word;
          rsp_nxt.pslverr = ~mapped;
        end
      end
      BUS_RESP:
      begin
        state_nxt       = BUS_IDLE;
        rsp_nxt.pready  = 1'b0;
        rsp_nxt.prdata  = WORD_RST;
        rsp_nxt.pslverr = 1'b0;
      end
      default:
      begin
        state_nxt = BUS_IDLE;
        rsp_nxt   = '0;
      end
    endcase
  end

  // pin synchronisers; stage one feeds stage two only
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      mrst_s1_r  <= 1'b0;
      mrst_s2_r  <= 1'b0;
      mrst_q_r   <= 1'b0;
      pause_s1_r <= 1'b0;
      pause_s2_r <= 1'b0;
    end
    else if (CE)
    begin
      mrst_s1_r  <= MASTER_RESET_IN;
      mrst_s2_r  <= mrst_s1_r;
      mrst_q_r   <= mrst_s2_r;
      pause_s1_r <= PAUSE_TRIGGER_IN;
      pause_s2_r <= pause_s1_r;
    end

  // counter reset sources
  wire sw_update = wr_swev & wd[BIT_SW_UPDATE_REQUEST];
  wire mrst_evt  = mrst_s2_r & ~mrst_q_r;
  wire ctr_clear = sw_update | mrst_evt;

  // counting and overflow
  wire              tick;
  wire [CNT_W-1:0]  reload_eff = reload_shadow_enable_r ? reload_act_r
                                                        : reload_pre_r;
  wire              ovf = tick & (counter_value_r == reload_eff);

  // update is blocked by the disable bit; reinit still happens
  wire upd_evt = ~update_disable_r & (ovf | ctr_clear);
  // flag source may be narrowed to overflow only
  wire flag_set = ~update_disable_r &
                  (ovf | (~update_source_select_r & ctr_clear));
  wire spm_stop = single_pulse_mode_r & upd_evt;

  wire [CNT_W-1:0] cnt_nxt =
    ctr_clear ? CNT_RST :
    wr_cnt    ? wd[CNT_W-1:0] :
    ovf       ? CNT_RST :
    tick      ? CNT_W'(counter_value_r + 16'h0001) : counter_value_r;

  // software write of enable wins over the single pulse stop
  wire cen_nxt = wr_ctl0  ? wd[BIT_COUNT_ENABLE] :
                 spm_stop ? 1'b0 : count_enable_r;

  // a clear write and an event in one cycle: the event wins
  wire flag_nxt = flag_set |
                  (update_event_flag_r &
                   ~(wr_flags & ~wd[BIT_UPDATE_EVENT_FLAG]));

  // trigger source selection; unlisted codes stay silent
  wire start_lvl = count_enable_r | pause_s2_r;
  wire start_evt = start_lvl & ~start_q_r;
  wire trg_nxt = (mms_r == TRG_ON_RESET)  ? ctr_clear :
                 (mms_r == TRG_ON_START)  ? start_evt :
                 (mms_r == TRG_ON_UPDATE) ? upd_evt   :
                 1'b0;

  timer_prescaler u_prescaler
  (
    .clk     (CLK),
    .rst_b   (RST_B),
    .ce      (CE),
    .run     (count_enable_r),
    .clear   (ctr_clear),
    .load    (upd_evt),
    .preload (prescaler_value_r),
    .tick    (tick)
  );

  // bus state and registered answer
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      state_r <= BUS_IDLE;
      rsp_r   <= '0;
    end
    else if (CE)
    begin
      state_r <= state_nxt;
      rsp_r   <= rsp_nxt;
    end

  // control registers written by software
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      update_disable_r       <= 1'b0;
      update_source_select_r <= 1'b0;
      single_pulse_mode_r    <= 1'b0;
      reload_shadow_enable_r <= 1'b0;
      mms_r                  <= MMS_RST;
      update_irq_enable_r    <= 1'b0;
      update_dma_enable_r    <= 1'b0;
      prescaler_value_r      <= PSC_RST;
      reload_pre_r           <= ARR_RST;
    end
    else if (CE)
    begin
      if (wr_ctl0)
      begin
        update_disable_r       <= wd[BIT_UPDATE_DISABLE];
        update_source_select_r <= wd[BIT_UPDATE_SOURCE];
        single_pulse_mode_r    <= wd[BIT_SINGLE_PULSE];
        reload_shadow_enable_r <= wd[BIT_RELOAD_SHADOW];
      end
      if (wr_ctl1)
        mms_r <= wd[MMS_MSB:MMS_LSB];
      if (wr_inten)
      begin
        update_irq_enable_r <= wd[BIT_UPDATE_IRQ_ENABLE];
        update_dma_enable_r <= wd[BIT_UPDATE_DMA_ENABLE];
      end
      if (wr_psc)
        prescaler_value_r <= wd[CNT_W-1:0];
      if (wr_arr)
        reload_pre_r <= wd[CNT_W-1:0];
    end

  // counting state and event flag
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      count_enable_r      <= 1'b0;
      counter_value_r     <= CNT_RST;
      reload_act_r        <= ARR_RST;
      update_event_flag_r <= 1'b0;
      start_q_r           <= 1'b0;
    end
    else if (CE)
    begin
      count_enable_r      <= cen_nxt;
      counter_value_r     <= cnt_nxt;
      update_event_flag_r <= flag_nxt;
      start_q_r           <= start_lvl;
      if (upd_evt)
        reload_act_r <= reload_pre_r;
    end

  // outputs straight from flops
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      trg_r <= 1'b0;
      dma_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else if (CE)
    begin
      trg_r <= trg_nxt;
      dma_r <= flag_set & update_dma_enable_r;
      irq_r <= flag_nxt & update_irq_enable_r;
    end

  assign APB_RSP        = rsp_r;
  assign TRIGGER_OUTPUT = trg_r;
  assign UPDATE_DMA_REQ = dma_r;
  assign UPDATE_IRQ     = irq_r;

endmodule
`default_nettype wire

// ---- timer_basic_assertions.sv ----
// bus answer and reserved bit checker of the up-count timer
`timescale 1ns/100ps
`default_nettype none
module timer_basic_chk
  import timer_pkg::*;
(
  input wire logic                CLK,
  input wire logic                RST_B,
  input wire logic                CE,
  input wire timer_pkg::apb_req_s APB_REQ,
  input wire timer_pkg::apb_rsp_s APB_RSP,
  input wire logic                MASTER_RESET_IN,
  input wire logic                PAUSE_TRIGGER_IN,
  input wire logic                TRIGGER_OUTPUT,
  input wire logic                UPDATE_DMA_REQ,
  input wire logic                UPDATE_IRQ
);
  // answer decode; master holds address while ready stands
  wire logic        rd  = APB_RSP.pready && !APB_REQ.pwrite;
  wire logic [7:0]  ad  = APB_REQ.paddr;
  wire logic [31:0] d   = APB_RSP.prdata;
  wire logic        map = ad inside {8'h00, 8'h04, 8'h0C, 8'h10,
                                     8'h14, 8'h24, 8'h28, 8'h2C};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  ready_pulse_a: assert property (CE && APB_RSP.pready
    |=> !APB_RSP.pready)
    else $error("ready stood longer than one cycle");
  ready_follows_a: assert property (CE && APB_REQ.psel && APB_REQ.penable
    && !APB_RSP.pready |=> APB_RSP.pready)
    else $error("no answer one cycle after access");
  unmapped_err_a: assert property (APB_RSP.pready && !map
    |-> APB_RSP.pslverr && (APB_REQ.pwrite || d == 32'h00000000))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (APB_RSP.pready && map |-> !APB_RSP.pslverr)
    else $error("mapped access refused");
  cnt_upper_a: assert property (rd && ad == 8'h24 |-> d[31:16] == 16'h0000)
    else $error("counter upper half not zero");
  psc_upper_a: assert property (rd && ad == 8'h28 |-> d[31:16] == 16'h0000)
    else $error("prescaler upper half not zero");
  mode_bits_a: assert property (rd && ad == 8'h04 |-> (d & ~32'h00000070) == 0)
    else $error("mode register reserved bits set");
  enable_bits_a: assert property (rd && ad == 8'h0C
    |-> (d & ~32'h00000101) == 0)
    else $error("enable register reserved bits set");
  flag_bits_a: assert property (rd && ad == 8'h10 |-> d[31:1] == 31'h0)
    else $error("flag register reserved bits set");
  req_zero_a: assert property (rd && ad == 8'h14 |-> d == 32'h00000000)
    else $error("update request reads nonzero");
  cover property (rd && ad == 8'h24);
  cover property (UPDATE_IRQ);
  cover property (TRIGGER_OUTPUT);
endmodule
bind timer_basic timer_basic_chk u_chk (.CLK(CLK), .RST_B(RST_B), .CE(CE),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .MASTER_RESET_IN(MASTER_RESET_IN),
  .PAUSE_TRIGGER_IN(PAUSE_TRIGGER_IN), .TRIGGER_OUTPUT(TRIGGER_OUTPUT),
  .UPDATE_DMA_REQ(UPDATE_DMA_REQ), .UPDATE_IRQ(UPDATE_IRQ));
`default_nettype wire

// ---- timer_basic_test.sv ----
// self-checking bench of the up-count timer
`timescale 1ns/100ps
`default_nettype none
module timer_basic_test;
  import timer_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        mri = 1'b0;
  logic        pti = 1'b0;
  logic        ce = 1'b1;
  apb_req_s    req = '0;
  apb_rsp_s    rsp;
  logic        trg, dma, irq;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0, n_trg = 0, n_dma = 0;
  logic [15:0] lf = 16'h0026;
  logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h0C, 8'h10,
                           8'h14, 8'h24, 8'h28, 8'h2C};
  logic [31:0] msk [8] = '{32'h8F, 32'h70, 32'h101, 32'h0,
                           32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFF};
  always #2.5 clk = ~clk;
  timer_basic dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .APB_REQ(req),
    .APB_RSP(rsp), .MASTER_RESET_IN(mri), .PAUSE_TRIGGER_IN(pti),
    .TRIGGER_OUTPUT(trg), .UPDATE_DMA_REQ(dma), .UPDATE_IRQ(irq));
  // pulse counters; cyc stamps reads for rate checks
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_trg <= n_trg + trg;
    n_dma <= n_dma + dma;
  end
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, g);
    tests_run++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  // counts sampled at uneven bus phases, so one tick of slack
  task automatic near(input string nm, input int x, input logic [31:0] g);
    tests_run++;
    if ($isunknown(g) || int'(g) + 1 < x || int'(g) > x + 1)
    begin
      n_errors++;
      $display("mismatch %s exp %0d got %0d", nm, x, g);
    end
  endtask
  // one apb transfer; ready and data taken at the completing rising edge
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q, output logic er,
    output int t);
    int i = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      n_errors++;
      final_report();
    end
    q = rsp.prdata;
    er = rsp.pslverr;
    t = cyc;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    int          t;
    bus(1'b1, a, d, q, e, t);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    int          t;
    bus(1'b0, a, 32'h0, q, e, t);
    chk($sformatf("reg %h", a), x, q);
  endtask
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic rate(input int dv);
    logic [31:0] v, w;
    logic        e;
    int          t0, t1;
    bus(1'b0, 8'h24, 32'h0, v, e, t0);
    repeat (200) @(posedge clk);
    bus(1'b0, 8'h24, 32'h0, w, e, t1);
    near("rate", (t1 - t0) / dv, w - v);
  endtask
  initial
  begin
    logic [31:0] v, w;
    logic        e;
    int          t, t1, n, p;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    bus(1'b0, 8'h08, 32'h0, v, e, t);
    chk("slverr", 32'h1, e);
    // random words, reserved bits must drop
    for (int i = 1; i < 8; i++)
    begin
      lf = nx(lf);
      wr(ofs[i], {lf, ~lf});
      rdc(ofs[i], {lf, ~lf} & msk[i]);
    end
    p = 2 + lf % 6;
    wr(8'h28, 32'h0);
    wr(8'h2C, 32'hFFFF);
    wr(8'h14, 32'h1);
    wr(8'h28, p);
    wr(8'h00, 32'h1);
    rate(1);
    wr(8'h14, 32'h1);
    bus(1'b0, 8'h24, 32'h0, v, e, t);
    near("cleared", 0, v);
    rate(p + 1);
    // clock enable low freezes the count and the prescaler
    bus(1'b0, 8'h24, 32'h0, v, e, t);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    bus(1'b0, 8'h24, 32'h0, w, e, t1);
    near("ce_hold", (t1 - t - 40) / (p + 1), w - v);
    // flag, irq level and dma pulse
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h101);
    wr(8'h10, 32'h0);
    n = n_dma;
    wr(8'h14, 32'h1);
    settle();
    rdc(8'h10, 32'h1);
    chk("irq", 32'h1, irq);
    chk("dma", n + 1, n_dma);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h14, 32'h0);
    wr(8'h14, 32'h1);
    settle();
    chk("irq", 32'h1, irq);
    chk("dma", n + 1, n_dma);
    wr(8'h10, 32'h0);
    settle();
    chk("irq", 32'h0, irq);
    // update disabled still clears; source select hides sw flag
    wr(8'h00, 32'h2);
    wr(8'h24, 32'h1234);
    wr(8'h14, 32'h1);
    rdc(8'h24, 32'h0);
    rdc(8'h10, 32'h0);
    wr(8'h00, 32'h4);
    wr(8'h2C, 32'h3);
    wr(8'h14, 32'h1);
    rdc(8'h10, 32'h0);
    wr(8'h00, 32'h5);
    repeat (60) @(posedge clk);
    rdc(8'h10, 32'h1);
    bus(1'b0, 8'h24, 32'h0, v, e, t);
    chk("wrap", 32'h1, v <= 32'h3);
    wr(8'h00, 32'h0);
    bus(1'b0, 8'h24, 32'h0, v, e, t);
    repeat (50) @(posedge clk);
    rdc(8'h24, v);
    wr(8'h00, 32'h9);
    repeat (60) @(posedge clk);
    rdc(8'h00, 32'h8);
    rdc(8'h24, 32'h0);
    // reload shadow on: a new reload waits for the next update
    wr(8'h2C, 32'hFFFF);
    wr(8'h14, 32'h1);
    wr(8'h2C, 32'h2);
    wr(8'h00, 32'h81);
    repeat (60) @(posedge clk);
    bus(1'b0, 8'h24, 32'h0, v, e, t);
    chk("shadow_reload", 32'h1, v > 32'h2);
    wr(8'h00, 32'h0);
    // trigger source for every mode code
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h04, m << 4);
      n = n_trg;
      wr(8'h14, 32'h1);
      settle();
      chk("trg", m == 0 || m == 2, n_trg - n);
    end
    wr(8'h04, 32'h10);
    n = n_trg;
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h0);
    @(posedge clk);
    pti <= 1'b1;
    repeat (6) @(posedge clk);
    pti <= 1'b0;
    settle();
    chk("trg_start", n + 2, n_trg);
    wr(8'h04, 32'h0);
    n = n_trg;
    @(posedge clk);
    mri <= 1'b1;
    repeat (6) @(posedge clk);
    mri <= 1'b0;
    settle();
    chk("trg_master", n + 1, n_trg);
    final_report();
  end
endmodule
`default_nettype wire

// ---- timer_pkg.sv ----
// shared constants, bus carriers and state codes of the up-count timer
package timer_pkg;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL_0      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_1      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DMA_IRQ_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS      = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SOFTWARE_EVENT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_VALUE  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_DIVIDER  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_AUTO_RELOAD    = 8'h2C;

  // field positions
  localparam int BIT_COUNT_ENABLE       = 0;
  localparam int BIT_UPDATE_DISABLE     = 1;
  localparam int BIT_UPDATE_SOURCE      = 2;
  localparam int BIT_SINGLE_PULSE       = 3;
  localparam int BIT_RELOAD_SHADOW      = 7;
  localparam int MMS_LSB                = 4;
  localparam int MMS_MSB                = 6;
  localparam int BIT_UPDATE_IRQ_ENABLE  = 0;
  localparam int BIT_UPDATE_DMA_ENABLE  = 8;
  localparam int BIT_UPDATE_EVENT_FLAG  = 0;
  localparam int BIT_SW_UPDATE_REQUEST  = 0;

  // master mode codes
  localparam logic [2:0] TRG_ON_RESET  = 3'h0;
  localparam logic [2:0] TRG_ON_START  = 3'h1;
  localparam logic [2:0] TRG_ON_UPDATE = 3'h2;

  // reset values
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  ARR_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  PSC_RST  = 16'h0000;
  localparam logic [2:0]        MMS_RST  = 3'h0;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h00000000;

  // apb request and answer
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_rsp_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_e;

endpackage

// ---- timer_prescaler.sv ----
// prescaler counter with preload and shadow copy
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler
  import timer_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] preload,
  output logic                  tick
);

  logic [CNT_W-1:0] shadow_r;
  logic [CNT_W-1:0] pcnt_r;
  logic [CNT_W-1:0] pcnt_nxt;

  // one tick every shadow+1 kernel cycles while running
  assign tick     = run & (pcnt_r == shadow_r);
  assign pcnt_nxt = clear ? PSC_RST :
                    tick  ? PSC_RST :
                    run   ? CNT_W'(pcnt_r + 16'h0001) : pcnt_r;

  // shadow only moves on an update, so a new divide ratio never splits a period
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      shadow_r <= PSC_RST;
      pcnt_r   <= PSC_RST;
    end
    else if (ce)
    begin
      if (load)
        shadow_r <= preload;
      pcnt_r <= pcnt_nxt;
    end

endmodule
`default_nettype wire
